/* File: core/spbl_pkg.sv */
// Shared constants and types for the serial boot loader ends
package spbl_pkg;
    // Strap codes {boot_select_ext, boot_select_link, boot_memory_select}
    localparam logic [2:0] STRAP_SERIAL = 3'h2;
    localparam logic [2:0] STRAP_NOBOOT = 3'h7;
    // Boot channel presets
    localparam logic [31:0] SPCTL_BOOT = 32'h0A00_1F81;
    localparam logic [31:0] SPCTL_DEFAULT = 32'h0000_0000;
    localparam logic [31:0] IDX_RESET = 32'h0004_0000;
    localparam logic [15:0] CNT_RESET = 16'h0180;
    localparam logic [31:0] KERNEL_ENTRY = 32'h0004_0005;
    localparam logic [31:0] NOBOOT_FETCH = 32'h0020_0004;
    localparam logic [8:0] KERNEL_WORDS = 9'h100;
    localparam logic [1:0] HDR_LAST = 2'h2;
    // Block tags
    localparam logic [7:0] TAG_FINAL = 8'h00;
    localparam logic [7:0] TAG_INT_LAST = 8'h12;
    localparam logic [7:0] TAG_EXT_LAST = 8'h1A;
    localparam logic [1:0] CLS_FINAL = 2'h0;
    localparam logic [1:0] CLS_INT = 2'h1;
    localparam logic [1:0] CLS_EXT = 2'h2;
    localparam logic [1:0] CLS_BAD = 2'h3;
    // Link timing: half period of the link clock, in CLK_IN cycles
    localparam logic [3:0] HALF_DIV = 4'h2;
    localparam logic [2:0] PRE_EDGES = 3'h4;
    localparam logic [4:0] WORD_LAST_BIT = 5'h1F;
    // Host register map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TXDATA = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int CTRL_EN = 0;
    localparam int CTRL_UNIT16 = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [5:0] {
        DEV_IDLE = 6'h01,
        DEV_LOAD = 6'h02,
        DEV_HDR = 6'h04,
        DEV_DATA = 6'h08,
        DEV_ZERO = 6'h10,
        DEV_RUN = 6'h20
    } spbl_dev_e;

    typedef enum logic [4:0] {
        HST_PRE = 5'h01,
        HST_IDLE = 5'h02,
        HST_LOW = 5'h04,
        HST_HIGH = 5'h08,
        HST_GAP = 5'h10
    } spbl_hst_e;
endpackage

/* File: core/spbl_if.sv */
// Serial boot link between the boot master and the loading device
`timescale 1ns/100ps
interface spbl_if;
    logic sclk;
    logic sel_n;
    logic mosi;

    modport dev (input sclk, input sel_n, input mosi);
    modport host (output sclk, output sel_n, output mosi);
endinterface

/* File: core/spbl_dev.sv */
// Device end: strap decode, serial word assembly and boot DMA
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module spbl_dev (
    input wire logic CLK_IN, // Core clock
    input wire logic SRST_IN, // Sync reset, high
    spbl_if.dev LINK, // Serial link from master
    input wire logic BOOT_SELECT_EXT_IN, // Strap pin
    input wire logic BOOT_SELECT_LINK_IN, // Strap pin
    input wire logic BOOT_MEMORY_SELECT_IN, // Strap pin
    output logic MEM_WE_OUT, // Memory write strobe
    output logic [31:0] MEM_ADDR_OUT, // Memory write address
    output logic [31:0] MEM_DATA_OUT, // Memory write data
    output logic [31:0] SERIAL_PORT_CONTROL_OUT, // Serial port setup
    output logic CORE_RELEASE_OUT, // Core may execute
    output logic [31:0] FETCH_ADDR_OUT, // First fetch address
    output logic [1:0] BLOCK_CLASS_OUT, // Class of last tag
    output logic BOOT_DONE_OUT // Whole image loaded
);
    typedef struct packed {
        logic [31:0] sh;
        logic [4:0] bits;
        logic [31:0] hold;
        logic tgl;
    } spbl_lnk_s;

    typedef struct packed {
        spbl_pkg::spbl_dev_e st;
        logic [2:0] p1;
        logic [2:0] p2;
        logic t1;
        logic t2;
        logic t3;
        logic [31:0] idx;
        logic [15:0] cnt;
        logic [31:0] addr;
        logic [1:0] hdr;
        logic fin;
        logic we;
        logic [31:0] waddr;
        logic [31:0] data;
        logic [31:0] spctl;
        logic rel;
        logic [31:0] fetch;
        logic [1:0] cls;
        logic done;
    } spbl_core_s;

    spbl_lnk_s l;
    spbl_lnk_s next_l;
    spbl_core_s r;
    spbl_core_s next_r;

    // Tag decode: final, internal, external, unknown
    function automatic logic [1:0] spbl_class(input logic [7:0] tag);
        if (tag == spbl_pkg::TAG_FINAL)
            spbl_class = spbl_pkg::CLS_FINAL;
        else if (tag <= spbl_pkg::TAG_INT_LAST)
            spbl_class = spbl_pkg::CLS_INT;
        else if (tag <= spbl_pkg::TAG_EXT_LAST)
            spbl_class = spbl_pkg::CLS_EXT;
        else
            spbl_class = spbl_pkg::CLS_BAD;
    endfunction

    // Zero-fill tags carry no data words
    function automatic logic spbl_is_zero(input logic [7:0] tag);
        case (tag)
            8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0F, 8'h11,
            8'h17, 8'h18, 8'h19, 8'h1A:
                spbl_is_zero = 1'b1;
            default:
                spbl_is_zero = 1'b0;
        endcase
    endfunction

    // Link side: shift MSB first, hand over each full 32-bit word
    always_comb
    begin
        next_l = l;
        if (LINK.sel_n)
        begin
            next_l.bits = 5'h00;
            next_l.tgl = 1'b0;
        end
        else
        begin
            next_l.sh = {l.sh[30:0], LINK.mosi};
            next_l.bits = l.bits + 5'h01;
            if (l.bits == spbl_pkg::WORD_LAST_BIT)
            begin
                next_l.hold = {l.sh[30:0], LINK.mosi};
                next_l.tgl = ~l.tgl;
            end
        end
    end

    always_ff @(posedge LINK.sclk)
    begin
        l <= next_l;
    end

    // Core side
    always_comb
    begin
        logic got;
        got = r.t2 ^ r.t3;
        next_r = r;
        next_r.we = 1'b0;
        next_r.p1 = {BOOT_SELECT_EXT_IN, BOOT_SELECT_LINK_IN, BOOT_MEMORY_SELECT_IN};
        next_r.p2 = r.p1;
        next_r.t1 = l.tgl;
        next_r.t2 = r.t1;
        next_r.t3 = r.t2;
        case (r.st)
            spbl_pkg::DEV_IDLE:
            begin
                if (r.p2 == spbl_pkg::STRAP_SERIAL)
                begin
                    next_r.spctl = spbl_pkg::SPCTL_BOOT;
                    next_r.idx = spbl_pkg::IDX_RESET;
                    next_r.cnt = spbl_pkg::CNT_RESET;
                    next_r.st = spbl_pkg::DEV_LOAD;
                end
                else if (r.p2 == spbl_pkg::STRAP_NOBOOT)
                begin
                    next_r.fetch = spbl_pkg::NOBOOT_FETCH;
                    next_r.rel = 1'b1;
                    next_r.st = spbl_pkg::DEV_RUN;
                end
            end
            spbl_pkg::DEV_LOAD:
            begin
                if (got)
                begin
                    next_r.we = 1'b1;
                    next_r.waddr = r.idx;
                    next_r.data = l.hold;
                    next_r.idx = r.idx + 32'h0000_0001;
                    next_r.cnt = r.cnt - 16'h0001;
                    if (r.cnt == 16'h0001)
                    begin
                        next_r.rel = 1'b1;
                        next_r.fetch = spbl_pkg::KERNEL_ENTRY;
                        next_r.hdr = 2'h0;
                        next_r.st = spbl_pkg::DEV_HDR;
                    end
                end
            end
            spbl_pkg::DEV_HDR:
            begin
                if (got)
                begin
                    next_r.hdr = r.hdr + 2'h1;
                    if (r.hdr == 2'h0)
                        next_r.cnt = l.hold[15:0];
                    else if (r.hdr == 2'h1)
                        next_r.addr = l.hold;
                    else
                    begin
                        next_r.hdr = 2'h0;
                        next_r.cls = spbl_class(l.hold[7:0]);
                        next_r.fin = 1'b0;
                        if (spbl_class(l.hold[7:0]) == spbl_pkg::CLS_FINAL)
                        begin
                            next_r.fin = 1'b1;
                            next_r.addr = spbl_pkg::IDX_RESET;
                            next_r.st = spbl_pkg::DEV_DATA;
                        end
                        else if (spbl_class(l.hold[7:0]) != spbl_pkg::CLS_BAD)
                            next_r.st = spbl_is_zero(l.hold[7:0]) ? spbl_pkg::DEV_ZERO : spbl_pkg::DEV_DATA;
                        if (r.cnt == 16'h0000)
                        begin
                            next_r.st = spbl_pkg::DEV_HDR;
                            if (spbl_class(l.hold[7:0]) == spbl_pkg::CLS_FINAL)
                            begin
                                next_r.done = 1'b1;
                                next_r.st = spbl_pkg::DEV_RUN;
                            end
                        end
                    end
                end
            end
            spbl_pkg::DEV_DATA, spbl_pkg::DEV_ZERO:
            begin
                if (got || r.st == spbl_pkg::DEV_ZERO)
                begin
                    next_r.we = 1'b1;
                    next_r.waddr = r.addr;
                    next_r.data = (r.st == spbl_pkg::DEV_ZERO) ? 32'h0000_0000 : l.hold;
                    next_r.addr = r.addr + 32'h0000_0001;
                    next_r.cnt = r.cnt - 16'h0001;
                    if (r.cnt == 16'h0001)
                    begin
                        next_r.st = r.fin ? spbl_pkg::DEV_RUN : spbl_pkg::DEV_HDR;
                        next_r.done = r.fin;
                    end
                end
            end
            spbl_pkg::DEV_RUN:
            begin
                next_r.st = spbl_pkg::DEV_RUN;
            end
            default:
            begin
                next_r.st = spbl_pkg::DEV_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            r <= '0;
            r.st <= spbl_pkg::DEV_IDLE;
            r.spctl <= spbl_pkg::SPCTL_DEFAULT;
            r.p1 <= next_r.p1;
            r.p2 <= next_r.p2;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign MEM_WE_OUT = r.we;
    assign MEM_ADDR_OUT = r.waddr;
    assign MEM_DATA_OUT = r.data;
    assign SERIAL_PORT_CONTROL_OUT = r.spctl;
    assign CORE_RELEASE_OUT = r.rel;
    assign FETCH_ADDR_OUT = r.fetch;
    assign BLOCK_CLASS_OUT = r.cls;
    assign BOOT_DONE_OUT = r.done;
endmodule // spbl_dev

/* File: core/spbl_host.sv */
// Boot master end: AXI4-Lite registers driving the serial link
`timescale 1ns/100ps
module spbl_host (
    input wire logic CLK_IN, // Core clock
    input wire logic SRST_IN, // Sync reset, high
    spbl_if.host LINK, // Serial link to device
    input wire logic [3:0] S_AXI_AWADDR_IN, // Write address
    input wire logic S_AXI_AWVALID_IN, // Write address valid
    output logic S_AXI_AWREADY_OUT, // Write address ready
    input wire logic [31:0] S_AXI_WDATA_IN, // Write data
    input wire logic [3:0] S_AXI_WSTRB_IN, // Write strobes
    input wire logic S_AXI_WVALID_IN, // Write data valid
    output logic S_AXI_WREADY_OUT, // Write data ready
    output logic [1:0] S_AXI_BRESP_OUT, // Write response
    output logic S_AXI_BVALID_OUT, // Write response valid
    input wire logic S_AXI_BREADY_IN, // Write response ready
    input wire logic [3:0] S_AXI_ARADDR_IN, // Read address
    input wire logic S_AXI_ARVALID_IN, // Read address valid
    output logic S_AXI_ARREADY_OUT, // Read address ready
    output logic [31:0] S_AXI_RDATA_OUT, // Read data
    output logic [1:0] S_AXI_RRESP_OUT, // Read response
    output logic S_AXI_RVALID_OUT, // Read data valid
    input wire logic S_AXI_RREADY_IN // Read data ready
);
    typedef struct packed {
        spbl_pkg::spbl_hst_e st;
        logic [3:0] dv;
        logic [2:0] pre;
        logic sclk;
        logic sel_n;
        logic mosi;
        logic [31:0] sh;
        logic [4:0] bits;
        logic [3:0] ub;
        logic busy;
        logic [1:0] ctrl;
        logic [15:0] sent;
        logic awr;
        logic bv;
        logic [1:0] bresp;
        logic arr;
        logic rv;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } spbl_host_s;

    spbl_host_s r;
    spbl_host_s next_r;

    always_comb
    begin
        logic tick;
        tick = (r.dv == spbl_pkg::HALF_DIV - 4'h1);
        next_r = r;
        next_r.dv = tick ? 4'h0 : r.dv + 4'h1;
        // Serial side
        case (r.st)
            spbl_pkg::HST_PRE:
            begin
                // Clock edges with select high align the device word counter
                if (tick)
                begin
                    next_r.sclk = ~r.sclk;
                    next_r.pre = r.pre + 3'h1;
                    if (r.pre == spbl_pkg::PRE_EDGES - 3'h1)
                        next_r.st = spbl_pkg::HST_IDLE;
                end
            end
            spbl_pkg::HST_IDLE:
            begin
                if (tick && r.busy && r.ctrl[spbl_pkg::CTRL_EN])
                begin
                    next_r.sel_n = 1'b0;
                    next_r.mosi = r.sh[31];
                    next_r.st = spbl_pkg::HST_LOW;
                end
            end
            spbl_pkg::HST_LOW:
            begin
                if (tick)
                begin
                    next_r.sclk = 1'b1;
                    next_r.st = spbl_pkg::HST_HIGH;
                end
            end
            spbl_pkg::HST_HIGH:
            begin
                if (tick)
                begin
                    next_r.sclk = 1'b0;
                    next_r.sh = {r.sh[30:0], 1'b0};
                    next_r.bits = r.bits + 5'h01;
                    next_r.ub = r.ub + 4'h1;
                    next_r.mosi = r.sh[30];
                    next_r.st = spbl_pkg::HST_LOW;
                    if (r.bits == spbl_pkg::WORD_LAST_BIT)
                    begin
                        next_r.busy = 1'b0;
                        next_r.sent = r.sent + 16'h0001;
                        next_r.sel_n = 1'b1;
                        next_r.st = spbl_pkg::HST_IDLE;
                    end
                    else if (r.ub == (r.ctrl[spbl_pkg::CTRL_UNIT16] ? 4'hF : 4'h7))
                    begin
                        next_r.sel_n = 1'b1;
                        next_r.ub = 4'h0;
                        next_r.st = spbl_pkg::HST_GAP;
                    end
                end
            end
            spbl_pkg::HST_GAP:
            begin
                if (tick)
                begin
                    next_r.sel_n = 1'b0;
                    next_r.st = spbl_pkg::HST_LOW;
                end
            end
            default:
            begin
                next_r.st = spbl_pkg::HST_IDLE;
            end
        endcase
        // Register write
        next_r.awr = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !r.awr && !r.bv;
        if (r.bv && S_AXI_BREADY_IN)
            next_r.bv = 1'b0;
        if (r.awr)
        begin
            next_r.bv = 1'b1;
            next_r.bresp = spbl_pkg::RESP_OKAY;
            if (S_AXI_AWADDR_IN == spbl_pkg::REG_CTRL)
            begin
                if (S_AXI_WSTRB_IN[0])
                    next_r.ctrl = S_AXI_WDATA_IN[1:0];
            end
            else if (S_AXI_AWADDR_IN == spbl_pkg::REG_TXDATA && !r.busy && S_AXI_WSTRB_IN == 4'hF)
            begin
                next_r.sh = S_AXI_WDATA_IN;
                next_r.busy = 1'b1;
                next_r.bits = 5'h00;
                next_r.ub = 4'h0;
            end
            else
                next_r.bresp = spbl_pkg::RESP_SLVERR;
        end
        // Register read
        next_r.arr = S_AXI_ARVALID_IN && !r.arr && !r.rv;
        if (r.rv && S_AXI_RREADY_IN)
            next_r.rv = 1'b0;
        if (r.arr)
        begin
            next_r.rv = 1'b1;
            next_r.rresp = spbl_pkg::RESP_OKAY;
            case (S_AXI_ARADDR_IN)
                spbl_pkg::REG_CTRL:
                    next_r.rdata = {30'h0000_0000, r.ctrl};
                spbl_pkg::REG_TXDATA:
                    next_r.rdata = r.sh;
                spbl_pkg::REG_STATUS:
                    next_r.rdata = {r.sent, 15'h0000, r.busy};
                default:
                begin
                    next_r.rdata = 32'h0000_0000;
                    next_r.rresp = spbl_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            r <= '0;
            r.st <= spbl_pkg::HST_PRE;
            r.sel_n <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign LINK.sclk = r.sclk;
    assign LINK.sel_n = r.sel_n;
    assign LINK.mosi = r.mosi;
    assign S_AXI_AWREADY_OUT = r.awr;
    assign S_AXI_WREADY_OUT = r.awr;
    assign S_AXI_BRESP_OUT = r.bresp;
    assign S_AXI_BVALID_OUT = r.bv;
    assign S_AXI_ARREADY_OUT = r.arr;
    assign S_AXI_RDATA_OUT = r.rdata;
    assign S_AXI_RRESP_OUT = r.rresp;
    assign S_AXI_RVALID_OUT = r.rv;
endmodule // spbl_host

/* File: bench/spbl_asserts.sv */
// Concurrent checks on the boot link clock and the device's load results
`timescale 1ns/100ps
module spbl_asserts (
    input wire logic CLK_IN, // Core clock
    input wire logic SRST_IN, // Sync reset
    input wire logic sclk, // Link clock
    input wire logic MEM_WE_OUT, // Write strobe
    input wire logic [31:0] MEM_ADDR_OUT, // Write address
    input wire logic [31:0] SERIAL_PORT_CONTROL_OUT, // Port setup
    input wire logic CORE_RELEASE_OUT, // Core released
    input wire logic [31:0] FETCH_ADDR_OUT, // First fetch
    input wire logic [1:0] BLOCK_CLASS_OUT, // Tag class
    input wire logic BOOT_DONE_OUT // Load finished
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SRST_IN);
    logic [11:0] wcount;
    logic [31:0] last_addr;
    // Count of the first 0x180 writes, the last one included, and their last address
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            wcount <= 12'h000;
            last_addr <= 32'h0000_0000;
        end
        else if (MEM_WE_OUT && wcount != 12'h180)
        begin
            wcount <= wcount + 12'h001;
            last_addr <= MEM_ADDR_OUT;
        end
    end
    property p_sclk_half;
        $rose(sclk) |=> sclk ##1 !sclk;
    endproperty
    a_sclk_half: assert property (p_sclk_half) else $error("link clock high time wrong");
    property p_boot_range;
        MEM_WE_OUT && !CORE_RELEASE_OUT |-> MEM_ADDR_OUT >= 32'h0004_0000 && MEM_ADDR_OUT < 32'h0004_0180;
    endproperty
    a_boot_range: assert property (p_boot_range) else $error("boot write outside image");
    property p_addr_step;
        MEM_WE_OUT && !CORE_RELEASE_OUT && MEM_ADDR_OUT != 32'h0004_0000 |-> MEM_ADDR_OUT == last_addr + 32'h1;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("boot address did not step by one");
    property p_word_gap;
        MEM_WE_OUT && !CORE_RELEASE_OUT |=> !MEM_WE_OUT [*8];
    endproperty
    a_word_gap: assert property (p_word_gap) else $error("boot writes too close");
    property p_we_ctrl;
        MEM_WE_OUT |-> SERIAL_PORT_CONTROL_OUT == 32'h0A00_1F81;
    endproperty
    a_we_ctrl: assert property (p_we_ctrl) else $error("write without boot port setup");
    property p_rel_fetch;
        $rose(CORE_RELEASE_OUT) && SERIAL_PORT_CONTROL_OUT == 32'h0A00_1F81 |-> ##[0:2] FETCH_ADDR_OUT == 32'h0004_0005;
    endproperty
    a_rel_fetch: assert property (p_rel_fetch) else $error("kernel entry wrong");
    property p_rel_count;
        $rose(CORE_RELEASE_OUT) && SERIAL_PORT_CONTROL_OUT == 32'h0A00_1F81 |=> wcount == 12'h180;
    endproperty
    a_rel_count: assert property (p_rel_count) else $error("release before full image");
    property p_done;
        $rose(BOOT_DONE_OUT) |-> CORE_RELEASE_OUT && BLOCK_CLASS_OUT == 2'h0;
    endproperty
    a_done: assert property (p_done) else $error("done without final block");
    property p_noboot;
        FETCH_ADDR_OUT == 32'h0020_0004 |-> !MEM_WE_OUT && SERIAL_PORT_CONTROL_OUT == 32'h0000_0000;
    endproperty
    a_noboot: assert property (p_noboot) else $error("no-boot mode loaded data");
    c_release: cover property ($rose(CORE_RELEASE_OUT) && SERIAL_PORT_CONTROL_OUT == 32'h0A00_1F81);
    c_ext: cover property (BLOCK_CLASS_OUT == 2'h2);
    c_done: cover property ($rose(BOOT_DONE_OUT));
    c_noboot: cover property (FETCH_ADDR_OUT == 32'h0020_0004);
endmodule // spbl_asserts

/* File: bench/serial_port_boot_loader_tb_top.sv */
// Bench: host and device ends joined, boot stream model and checks
`timescale 1ns/100ps
module serial_port_boot_loader_tb_top;
    logic CLK_IN = 1'b0;
    logic SRST_IN = 1'b1;
    logic strap_ext = 1'b0, strap_link = 1'b1, strap_mem = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, mem_we, rel, done;
    logic [1:0] bresp, rresp, blk_cls;
    logic [31:0] rdata, mem_addr, mem_data, spctl, fetch;
    logic [31:0] seed = 32'h6df3_fc2c;
    logic [63:0] exp_q[$];
    int err_count = 0;
    int checks_done = 0;
    int sent_n = 0;
    spbl_if lnk();
    spbl_dev i_spbl_dev (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .LINK(lnk.dev), .BOOT_SELECT_EXT_IN(strap_ext),
        .BOOT_SELECT_LINK_IN(strap_link), .BOOT_MEMORY_SELECT_IN(strap_mem), .MEM_WE_OUT(mem_we),
        .MEM_ADDR_OUT(mem_addr), .MEM_DATA_OUT(mem_data), .SERIAL_PORT_CONTROL_OUT(spctl), .CORE_RELEASE_OUT(rel),
        .FETCH_ADDR_OUT(fetch), .BLOCK_CLASS_OUT(blk_cls), .BOOT_DONE_OUT(done));
    spbl_host i_spbl_host (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .LINK(lnk.host), .S_AXI_AWADDR_IN(awaddr),
        .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb),
        .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready));
    spbl_asserts i_spbl_asserts (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .sclk(lnk.sclk), .MEM_WE_OUT(mem_we),
        .MEM_ADDR_OUT(mem_addr), .SERIAL_PORT_CONTROL_OUT(spctl), .CORE_RELEASE_OUT(rel), .FETCH_ADDR_OUT(fetch),
        .BLOCK_CLASS_OUT(blk_cls), .BOOT_DONE_OUT(done));
    initial
        forever #5 CLK_IN = ~CLK_IN;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [1:0] tag_class(input logic [7:0] t);
        if (t == 8'h00)
            return 2'h0;
        if (t <= 8'h12)
            return 2'h1;
        return (t <= 8'h1A) ? 2'h2 : 2'h3;
    endfunction
    task automatic tally_and_finish();
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic fail_wait();
        err_count++;
        tally_and_finish();
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_word({30'h0, got}, {30'h0, exp});
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        bit got, ga, gw;
        got = 0;
        @(posedge CLK_IN);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'b111};
        for (int n = 0; n < 50 && !got; n++)
        begin
            @(negedge CLK_IN);
            {got, ga, gw, r} = {bvalid === 1'b1, awready === 1'b1, wready === 1'b1, bresp};
            @(posedge CLK_IN);
            if (ga)
                awvalid <= 1'b0;
            if (gw)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!got)
            fail_wait();
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        bit got, ga;
        got = 0;
        @(posedge CLK_IN);
        {araddr, arvalid, rready} <= {a, 2'b11};
        for (int n = 0; n < 50 && !got; n++)
        begin
            @(negedge CLK_IN);
            {got, ga, d, r} = {rvalid === 1'b1, arready === 1'b1, rdata, rresp};
            @(posedge CLK_IN);
            if (ga)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!got)
            fail_wait();
    endtask
    task automatic wait_idle();
        logic [31:0] st;
        logic [1:0] r;
        st = 32'h0000_0001;
        for (int n = 0; n < 200 && st[0] !== 1'b0; n++)
            axi_rd(spbl_pkg::REG_STATUS, st, r);
        if (st[0] !== 1'b0)
            fail_wait();
        repeat (12) @(posedge CLK_IN);
    endtask
    task automatic send_word(input logic [31:0] d);
        logic [1:0] r;
        wait_idle();
        axi_wr(spbl_pkg::REG_TXDATA, d, 4'hF, r);
        cmp_resp(r, spbl_pkg::RESP_OKAY);
        sent_n++;
    endtask
    task automatic block(input logic [15:0] cnt, input logic [31:0] adr, input logic [7:0] tag, input bit zero);
        logic [31:0] d, base;
        base = (tag == 8'h00) ? 32'h0004_0000 : adr;
        send_word({16'h0000, cnt});
        send_word(adr);
        for (int i = 0; i < cnt && zero; i++)
            exp_q.push_back({base + 32'(i), 32'h0000_0000});
        send_word({24'h00_0000, tag});
        for (int i = 0; i < cnt && !zero; i++)
        begin
            d = rnd();
            exp_q.push_back({base + 32'(i), d});
            send_word(d);
        end
        wait_idle();
        cmp_word({30'h0, blk_cls}, {30'h0, tag_class(tag)});
    endtask
    // Every write is matched against the model in order
    always @(posedge CLK_IN)
    begin
        if (mem_we === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp_word(mem_addr, 32'hFFFF_FFFF);
            else
            begin
                cmp_word(mem_addr, exp_q[0][63:32]);
                cmp_word(mem_data, exp_q[0][31:0]);
                void'(exp_q.pop_front());
            end
        end
    end
    initial
    begin
        logic [31:0] v;
        logic [1:0] r;
        repeat (3) @(posedge CLK_IN);
        SRST_IN <= 1'b0;
        axi_rd(4'hC, v, r);
        cmp_resp(r, spbl_pkg::RESP_SLVERR);
        cmp_word(v, 32'h0000_0000);
        for (int i = 0; i < 384; i++)
        begin
            if (i % 128 == 0)
            begin
                wait_idle();
                axi_wr(spbl_pkg::REG_CTRL, {30'h0, i[7], 1'b1}, 4'h1, r);
                axi_rd(spbl_pkg::REG_CTRL, v, r);
                cmp_word(v, {30'h0, i[7], 1'b1});
            end
            v = (i == 4) ? 32'h0000_0000 : rnd();
            exp_q.push_back({32'h0004_0000 + 32'(i), v});
            send_word(v);
            if (i == 0)
            begin
                axi_wr(spbl_pkg::REG_TXDATA, v, 4'hF, r);
                cmp_resp(r, spbl_pkg::RESP_SLVERR);
                axi_wr(spbl_pkg::REG_TXDATA, v, 4'h3, r);
                cmp_resp(r, spbl_pkg::RESP_SLVERR);
            end
        end
        wait_idle();
        for (int n = 0; n < 100 && rel !== 1'b1; n++)
            @(posedge CLK_IN);
        cmp_word({31'h0, rel}, 32'h0000_0001);
        cmp_word(fetch, 32'h0004_0005);
        cmp_word(spctl, 32'h0A00_1F81);
        axi_rd(spbl_pkg::REG_STATUS, v, r);
        cmp_word({16'h0, v[31:16]}, 32'(sent_n));
        for (int t = 1; t <= 27; t++)
            block(16'h0000, 32'h0005_0000, 8'(t), 1'b0);
        block(16'h0003, 32'h0005_1000, 8'h01, 1'b1);
        block(16'h0002, 32'h0005_2000, 8'h05, 1'b0);
        block(16'h0001, 32'h0005_3000, 8'h00, 1'b0);
        cmp_word({31'h0, done}, 32'h0000_0001);
        cmp_word(32'(exp_q.size()), 32'h0000_0000);
        SRST_IN <= 1'b1;
        {strap_ext, strap_link, strap_mem} <= 3'b111;
        repeat (4) @(posedge CLK_IN);
        SRST_IN <= 1'b0;
        axi_wr(spbl_pkg::REG_CTRL, 32'h0000_0001, 4'h1, r);
        send_word(rnd());
        wait_idle();
        cmp_word(fetch, 32'h0020_0004);
        cmp_word(spctl, 32'h0000_0000);
        tally_and_finish();
    end
endmodule // serial_port_boot_loader_tb_top
